// ===== bench/lxd_diag_test.sv
// Self-checking bench of the diagnostics block
`timescale 1ns/1ps
`include "lxd_defs.svh"
module lxd_diag_test
    import lxd_pkg::*;
;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    lxd_req_s        req;
    lxd_adc_s        adc = '0;
    lxd_buck_s [1:0] buck = '0;
    logic      [1:0] dim = 2'b00;
    logic            link_err = 1'b0;
    logic            pin = 1'b1, seq = 1'b0;
    logic     [15:0] rdata, d;
    logic      [1:0] run, fot, ote, fm;
    logic      [3:0] rng;
    logic      [7:0] c;
    logic     [15:0] q [$];
    integer          num_errors = 0, n_tests = 0, seed = 32'h33F9, i, n;
    always #12.5 clk = ~clk;
    lxd_mcu mcu (.clk(clk), .req(req), .rdata(rdata));
    lxd_diag dut (.clk(clk), .rst_n(rst_n), .reset_pin_n(pin),
        .req(req), .rdata(rdata), .adc(adc), .adc_seq_done(seq),
        .dim_control_input(dim), .buck(buck), .link_err(link_err),
        .buck_run(run), .string_range_select(rng), .force_measure(fm),
        .fixed_off_time(fot), .off_time_end(ote));
    // Expected result word: odd parity above the code
    function automatic logic [15:0] par(input logic [7:0] v);
        par = {7'h00, ~^v, v};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        mcu.rd(a, v);
        chk(v, exp);
    endtask
    // Pipeline needs a few cycles before flags and results settle
    task automatic conv(input lxd_src_e s, input logic [7:0] v);
        @(negedge clk);
        adc <= '{valid: 1'b1, src: s, code: v};
        @(negedge clk);
        adc <= '0;
        repeat (3) @(negedge clk);
    endtask
    task automatic finish_test;
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #200000;
        num_errors = num_errors + 1;
        finish_test;
    end
    initial
    begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        rdchk(`LXD_WARN_THR_OFS, 16'h00B3);
        rdchk(`LXD_DEV_FAULT_OFS, 16'h0008);
        rdchk(`LXD_DEV_FAULT_OFS, 16'h0000);
        rdchk(8'h20, 16'h0000);
        for (i = 0; i < 5; i = i + 1)
        begin
            c = $random(seed);
            // Keep temperature clear of the warning level here
            if (i == 2)
                c[7] = 1'b0;
            q.push_back(par(c));
            conv(lxd_src_e'(i), c);
            rdchk(`LXD_RESULT_BASE + i[7:0], q.pop_front());
        end
        rdchk(8'h0D, 16'h0100);
        for (i = 0; i < 4; i = i + 1)
        begin
            mcu.wr(`LXD_CTRL_OFS, {8'h00, i[1:0], i[1:0], 4'hF});
            chk({12'h000, rng}, {12'h000, i[1:0], i[1:0]});
        end
        dim <= 2'b11;
        repeat (12) @(negedge clk);
        chk({14'h0000, run}, 16'h0003);
        rdchk(`LXD_LED_FAULT_OFS, 16'h0F00);
        mcu.wr(`LXD_WARN_THR_OFS, 16'h0090);
        conv(LXD_SRC_TEMP, 8'h90);
        rdchk(`LXD_DEV_FAULT_OFS, 16'h0001);
        conv(LXD_SRC_TEMP, 8'hD0);
        chk({14'h0000, run}, 16'h0000);
        rdchk(`LXD_DEV_FAULT_OFS, 16'h0003);
        conv(LXD_SRC_TEMP, 8'hA0);
        chk({14'h0000, run}, 16'h0000);
        conv(LXD_SRC_TEMP, 8'h8F);
        chk({14'h0000, run}, 16'h0003);
        mcu.rd(`LXD_DEV_FAULT_OFS, d);
        rdchk(`LXD_DEV_FAULT_OFS, 16'h0000);
        @(negedge clk);
        link_err <= 1'b1;
        @(negedge clk);
        link_err <= 1'b0;
        rdchk(`LXD_DEV_FAULT_OFS, 16'h0004);
        buck[0].short_cmp <= 1'b1;
        repeat (2) @(negedge clk);
        chk({12'h000, fot, ote}, 16'h0004);
        rdchk(`LXD_LED_FAULT_OFS, 16'h0F04);
        buck[0].short_cmp <= 1'b0;
        mcu.rd(`LXD_LED_FAULT_OFS, d);
        rdchk(`LXD_LED_FAULT_OFS, 16'h0F00);
        buck[1].min_ton <= 1'b1;
        @(negedge clk);
        buck[1].min_ton <= 1'b0;
        rdchk(`LXD_LED_FAULT_OFS, 16'h0F80);
        rdchk(`LXD_LED_FAULT_OFS, 16'h0F00);
        mcu.wr(`LXD_FORCED_PER_OFS, 16'h0003);
        for (i = 1; i < 4; i = i + 1)
        begin
            @(negedge clk);
            seq <= 1'b1;
            @(negedge clk);
            seq <= 1'b0;
            chk({14'h0000, fm}, (i == 3) ? 16'h0003 : 16'h0000);
        end
        // Second pulse reaches the open limit of 50 us
        for (i = 0; i < 2; i = i + 1)
        begin
            n = i ? 2000 : 1 + {$random(seed)} % 200;
            buck[0].on_phase <= 1'b1;
            repeat (n) @(negedge clk);
            buck[0].on_phase <= 1'b0;
            rdchk(`LXD_ON_TIME0_OFS, 16'(n * 25 / 200));
        end
        chk({14'h0000, run}, 16'h0003);
        rdchk(`LXD_LED_FAULT_OFS, 16'h0F01);
        buck[1].oc_over <= 1'b1;
        buck[1].period_tick <= 1'b1;
        @(negedge clk);
        buck[1].period_tick <= 1'b0;
        chk({14'h0000, run}, 16'h0001);
        rdchk(`LXD_LED_FAULT_OFS, 16'h0D20);
        buck[1].oc_over <= 1'b0;
        rdchk(`LXD_LED_FAULT_OFS, 16'h0D00);
        chk({14'h0000, run}, 16'h0003);
        mcu.wr(`LXD_CTRL_OFS, 16'h0003);
        conv(LXD_SRC_TEMP, 8'hD0);
        conv(LXD_SRC_TEMP, 8'h8F);
        chk({14'h0000, run}, 16'h0000);
        mcu.wr(`LXD_CTRL_OFS, 16'h0000);
        mcu.wr(`LXD_CTRL_OFS, 16'h0003);
        @(negedge clk);
        chk({14'h0000, run}, 16'h0003);
        pin <= 1'b0;
        repeat (3) @(negedge clk);
        pin <= 1'b1;
        chk({14'h0000, run}, 16'h0000);
        rdchk(`LXD_WARN_THR_OFS, 16'h00B3);
        rdchk(`LXD_DEV_FAULT_OFS, 16'h0000);
        finish_test;
    end
endmodule

// ===== bench/lxd_mcu.sv
// Register master model standing in for the controller
`timescale 1ns/1ps
module lxd_mcu
    import lxd_pkg::*;
(
    input  wire logic        clk,
    output lxd_req_s         req,
    input  wire logic [15:0] rdata
);
    initial req = '0;
    // Held across exactly one rising edge, so every access is a single pulse
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(negedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk);
        v = rdata;
        req <= '0;
    endtask
endmodule

// ===== core/lxd_defs.svh
// Register offsets, reset values and timing counts of the diagnostics block
`ifndef LXD_DEFS_SVH
`define LXD_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LXD_CTRL_OFS        8'h01
`define LXD_WARN_THR_OFS    8'h02
`define LXD_FORCED_PER_OFS  8'h03
`define LXD_FS_MODE_OFS     8'h04
`define LXD_ON_TIME0_OFS    8'h05
`define LXD_ON_TIME1_OFS    8'h06
`define LXD_RESULT_BASE     8'h08
`define LXD_RESULT_LAST     8'h0E
`define LXD_LED_FAULT_OFS   8'h13
`define LXD_DEV_FAULT_OFS   8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define LXD_PARITY_BIT      8
`define LXD_CTRL_EN_LSB     0
`define LXD_CTRL_AUTO_LSB   2
`define LXD_CTRL_RANGE_LSB  4
`define LXD_CTRL_OCLIM_LSB  8
`define LXD_STR_ON_IDX0     3'h5

// ****************************************************************
// Reset values
// ****************************************************************
`define LXD_WARN_THR_RST    8'hB3
`define LXD_CTRL_RST        16'h0000
`define LXD_FORCED_PER_RST  9'h000
`define LXD_FS_MODE_RST     3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define LXD_CLK_KHZ         40000
`define LXD_DEB_NS          200
`define LXD_DEB_CYC         ((`LXD_DEB_NS * `LXD_CLK_KHZ + 999999) / 1000000)
`define LXD_TON_LSB_NS      200
`define LXD_TON_LSB_CYC     ((`LXD_TON_LSB_NS * `LXD_CLK_KHZ) / 1000000)
`define LXD_OPEN_NS         50000
`define LXD_OPEN_CYC        ((`LXD_OPEN_NS * `LXD_CLK_KHZ) / 1000000)

`endif

// ===== core/lxd_diag.sv
// Monitoring and diagnostic logic of the two-channel LED driver
// Overview of operation
// - Supply code stored 8-bit with odd parity, 4 V full scale.
// - Boost code stored 8-bit with odd parity, 70 V full scale.
// - Every result register, string voltages included, carries odd parity.
// - Parity sits in bit 8 above the value in bits 7..0.
// - Die temperature code kept and reused for warning and shutdown.
// - Two-bit range select per channel picks 70, 50, 40 or 30 V.
// - Constant dimming input still forces periodic string measurements.
// - Forced period equals nonzero setting times one converter sequence.
// - Warning flag latches when temperature code reaches warning threshold.
// - Warning threshold resets to code 179.
// - Shutdown disables both channels and latches shutdown flag.
// - Shutdown exits only when temperature falls below warning level.
// - After shutdown, auto channels restart; others need enable rising edge.
// - Serial link errors latch the link error flag.
// - On-time overflow at 50 us latches open flag, channel stays on.
// - Comparator below minimum limit latches channel short flag.
// - Short selects fixed off-time; zero-cross variant ends it early.
// - Overcurrent latches flag and disables the channel.
// - Overcurrent count to limit plus one; off until flag read.
// - Live status bit is 1 exactly while channel regulates.
// - Readable dimming input levels after 200 ns debouncer.
// - Minimum on-time flag latches per channel, cleared on read.
// - On-time register in 200 ns codes, zero below, held when stopped.
// - Hardware-reset flag sets only on power-on reset.
// - Power-on always resets; pin falling edge resets in modes 0,1,6,7.
`timescale 1ns/1ps
`include "lxd_defs.svh"

module lxd_diag
    import lxd_pkg::*;
#(
    parameter logic [7:0] TSD_CODE   = 8'hD0,
    parameter bit         ZERO_CROSS = 1'b0
)
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            reset_pin_n,
    input  wire lxd_req_s        req,
    output logic          [15:0] rdata,
    input  wire lxd_adc_s        adc,
    input  wire logic            adc_seq_done,
    input  wire logic      [1:0] dim_control_input,
    input  wire lxd_buck_s [1:0] buck,
    input  wire logic            link_err,
    output logic           [1:0] buck_run,
    output logic           [3:0] string_range_select,
    output logic           [1:0] force_measure,
    output logic           [1:0] fixed_off_time,
    output logic           [1:0] off_time_end
);

    localparam logic [11:0] OPEN_CYC = 12'(`LXD_OPEN_CYC);
    localparam logic [3:0]  DEB_CYC  = 4'(`LXD_DEB_CYC);

    // ****************************************************************
    // Reset pin handling
    // ****************************************************************
    logic       pin_q;
    logic       pin_rst;
    logic       next_pin_rst;
    logic       core_rst_n;
    logic [2:0] failsafe_mode_sel;

    always_comb
    begin
        next_pin_rst = pin_q && !reset_pin_n && !pin_rst
            && (failsafe_mode_sel[2] == failsafe_mode_sel[1]);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_q   <= 1'b1;
            pin_rst <= 1'b0;
        end
        else
        begin
            pin_q   <= reset_pin_n;
            pin_rst <= next_pin_rst;
        end
    end

    // Reset pulse comes from a flop so it cannot glitch
    assign core_rst_n = rst_n && !pin_rst;

    // Checks below stay quiet while either reset source is active
    default clocking @(posedge clk); endclocking
    default disable iff (!core_rst_n);

    // ****************************************************************
    // Control, results and flags
    // ****************************************************************
    logic [15:0] ctrl,        next_ctrl;
    logic [7:0]  warn_temp_threshold, next_warn;
    logic [8:0]  forced_measure_period, next_fmp;
    logic [2:0]  next_fs_mode;
    logic [7:0]  die_temp_code, next_temp;
    logic [1:0]  open_string_flag, short_string_flag, overcurrent_flag;
    logic [1:0]  min_on_time_flag, next_open, next_short, next_oc, next_mint;
    logic        thermal_warning_flag, thermal_shutdown_flag;
    logic        link_error_flag, next_tw, next_tsd, next_lerr;
    logic        hw_reset_flag, next_hwr;
    lxd_therm_e  therm, next_therm;
    logic        rd_led, rd_dev, wr_any;
    logic [1:0]  dim_input_level, open_set, oc_set;
    logic [7:0]  on_time_measure [2];
    logic [6:0]  mem_we;
    logic [8:0]  mem_rdata;
    logic [15:0] rd_val, next_rd_val;
    logic        rd_mem, next_rd_mem;
    logic        shutdown_entry;

    assign rd_led = req.rd && (req.addr == `LXD_LED_FAULT_OFS);
    assign rd_dev = req.rd && (req.addr == `LXD_DEV_FAULT_OFS);
    assign wr_any = req.wr;
    assign shutdown_entry = (therm == LXD_TH_NORMAL)
        && (die_temp_code >= TSD_CODE);
    assign string_range_select = ctrl[`LXD_CTRL_RANGE_LSB +: 4];

    always_comb
    begin
        next_ctrl    = ctrl;
        next_warn    = warn_temp_threshold;
        next_fmp     = forced_measure_period;
        next_fs_mode = failsafe_mode_sel;
        if (wr_any)
        begin
            unique case (req.addr)
                `LXD_CTRL_OFS:       next_ctrl    = req.wdata;
                `LXD_WARN_THR_OFS:   next_warn    = req.wdata[7:0];
                `LXD_FORCED_PER_OFS: next_fmp     = req.wdata[8:0];
                `LXD_FS_MODE_OFS:    next_fs_mode = req.wdata[2:0];
                default:             next_ctrl    = ctrl;
            endcase
        end
        next_temp = die_temp_code;
        if (adc.valid && adc.src == LXD_SRC_TEMP)
            next_temp = adc.code;
        next_therm = therm;
        unique case (therm)
            LXD_TH_NORMAL:
                if (die_temp_code >= TSD_CODE)
                    next_therm = LXD_TH_SHUTDOWN;
            LXD_TH_SHUTDOWN:
                if (die_temp_code < warn_temp_threshold)
                    next_therm = LXD_TH_NORMAL;
        endcase
        // Set wins over the clearing read
        next_open  = open_set | (open_string_flag & ~{2{rd_led}});
        next_short = {buck[1].short_cmp, buck[0].short_cmp}
            | (short_string_flag & ~{2{rd_led}});
        next_oc    = oc_set | (overcurrent_flag & ~{2{rd_led}});
        next_mint  = {buck[1].min_ton, buck[0].min_ton}
            | (min_on_time_flag & ~{2{rd_led}});
        next_tw    = (die_temp_code >= warn_temp_threshold)
            || (thermal_warning_flag && !rd_dev);
        next_tsd   = shutdown_entry || (thermal_shutdown_flag && !rd_dev);
        next_lerr  = link_err || (link_error_flag && !rd_dev);
        next_hwr   = hw_reset_flag && !rd_dev;
    end

    always_ff @(posedge clk or negedge core_rst_n)
    begin
        if (!core_rst_n)
        begin
            ctrl                  <= `LXD_CTRL_RST;
            warn_temp_threshold   <= `LXD_WARN_THR_RST;
            forced_measure_period <= `LXD_FORCED_PER_RST;
            failsafe_mode_sel     <= `LXD_FS_MODE_RST;
            die_temp_code         <= 8'h00;
            therm                 <= LXD_TH_NORMAL;
            open_string_flag      <= 2'h0;
            short_string_flag     <= 2'h0;
            overcurrent_flag      <= 2'h0;
            min_on_time_flag      <= 2'h0;
            thermal_warning_flag  <= 1'b0;
            thermal_shutdown_flag <= 1'b0;
            link_error_flag       <= 1'b0;
        end
        else
        begin
            ctrl                  <= next_ctrl;
            warn_temp_threshold   <= next_warn;
            forced_measure_period <= next_fmp;
            failsafe_mode_sel     <= next_fs_mode;
            die_temp_code         <= next_temp;
            therm                 <= next_therm;
            open_string_flag      <= next_open;
            short_string_flag     <= next_short;
            overcurrent_flag      <= next_oc;
            min_on_time_flag      <= next_mint;
            thermal_warning_flag  <= next_tw;
            thermal_shutdown_flag <= next_tsd;
            link_error_flag       <= next_lerr;
        end
    end

    // Pin reset must not touch this one
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hw_reset_flag <= 1'b1;
        else
            hw_reset_flag <= next_hwr;
    end

    // ****************************************************************
    // Per-channel logic
    // ****************************************************************
    for (genvar i = 0; i < 2; i++)
    begin : g_ch
        logic [3:0]  deb_cnt, next_deb_cnt;
        logic        deb, next_deb, deb_prev, en_prev, tsd_lock, next_lock;
        logic [11:0] on_cnt, next_on_cnt;
        logic [7:0]  ton, next_ton;
        logic        phase_q;
        logic [2:0]  oc_cnt, next_oc_cnt, oc_lim;
        logic        oc_block, next_block, en, run;
        logic [8:0]  fcnt, next_fcnt;
        logic        next_force;

        assign en     = ctrl[`LXD_CTRL_EN_LSB + i];
        assign oc_lim = {1'b0, ctrl[`LXD_CTRL_OCLIM_LSB + 2*i +: 2]} + 3'h1;
        assign run    = en && deb && !tsd_lock && !oc_block
            && therm == LXD_TH_NORMAL;
        assign buck_run[i]        = run;
        assign dim_input_level[i] = deb;
        assign on_time_measure[i] = ton;
        assign fixed_off_time[i]  = buck[i].short_cmp;
        assign off_time_end[i]    = ZERO_CROSS && buck[i].short_cmp
            && buck[i].zero_cross;
        assign open_set[i] = run && buck[i].on_phase
            && on_cnt == OPEN_CYC - 12'h001;
        assign oc_set[i]   = next_block && !oc_block;

        always_comb
        begin
            next_deb     = deb;
            next_deb_cnt = 4'h0;
            if (dim_control_input[i] != deb)
            begin
                next_deb_cnt = deb_cnt + 4'h1;
                if (deb_cnt == DEB_CYC - 4'h1)
                begin
                    next_deb     = dim_control_input[i];
                    next_deb_cnt = 4'h0;
                end
            end
            next_lock = tsd_lock;
            if (shutdown_entry && !ctrl[`LXD_CTRL_AUTO_LSB + i])
                next_lock = 1'b1;
            else if (therm == LXD_TH_NORMAL && en && !en_prev)
                next_lock = 1'b0;
            next_on_cnt = on_cnt;
            next_ton    = ton;
            if (run && buck[i].on_phase)
            begin
                if (on_cnt != 12'hFFF)
                    next_on_cnt = on_cnt + 12'h001;
            end
            else if (phase_q)
            begin
                // Clamp long pulses; 3-bit shift equals 200 ns per code
                next_ton = (on_cnt[11] == 1'b0 && on_cnt[10:3] != 8'hFF)
                    ? on_cnt[10:3] : 8'hFF;
                if (on_cnt[11])
                    next_ton = 8'hFF;
                next_on_cnt = 12'h000;
            end
            next_oc_cnt = oc_cnt;
            next_block  = oc_block;
            if (!en || !buck[i].oc_over || (deb && !deb_prev))
                next_oc_cnt = 3'h0;
            else if (buck[i].period_tick && !oc_block)
                next_oc_cnt = oc_cnt + 3'h1;
            if (next_oc_cnt == oc_lim)
                next_block = 1'b1;
            else if (rd_led)
                next_block = 1'b0;
            next_fcnt  = fcnt;
            next_force = 1'b0;
            if (deb != deb_prev)
                next_fcnt = 9'h000;
            else if (adc_seq_done && forced_measure_period != 9'h000)
            begin
                next_fcnt = fcnt + 9'h001;
                if (next_fcnt == forced_measure_period)
                begin
                    next_force = 1'b1;
                    next_fcnt  = 9'h000;
                end
            end
        end

        always_ff @(posedge clk or negedge core_rst_n)
        begin
            if (!core_rst_n)
            begin
                deb_cnt          <= 4'h0;
                deb              <= 1'b0;
                deb_prev         <= 1'b0;
                en_prev          <= 1'b0;
                tsd_lock         <= 1'b0;
                on_cnt           <= 12'h000;
                ton              <= 8'h00;
                phase_q          <= 1'b0;
                oc_cnt           <= 3'h0;
                oc_block         <= 1'b0;
                fcnt             <= 9'h000;
                force_measure[i] <= 1'b0;
            end
            else
            begin
                deb_cnt          <= next_deb_cnt;
                deb              <= next_deb;
                deb_prev         <= deb;
                en_prev          <= en;
                tsd_lock         <= next_lock;
                on_cnt           <= next_on_cnt;
                ton              <= next_ton;
                phase_q          <= run && buck[i].on_phase;
                oc_cnt           <= next_oc_cnt;
                oc_block         <= next_block;
                fcnt             <= next_fcnt;
                force_measure[i] <= next_force;
            end
        end

        property p_oc_off;
            oc_block |-> !run;
        endproperty
        a_oc_off: assert property (p_oc_off) else $error("oc run");

        property p_ton_zero;
            (phase_q && !(run && buck[i].on_phase) && on_cnt < 12'h008)
                |=> ton == 8'h00;
        endproperty
        a_ton_zero: assert property (p_ton_zero) else $error("ton");

        property p_open;
            open_set[i] |=> open_string_flag[i] && run == $past(run);
        endproperty
        a_open: assert property (p_open) else $error("open");

        // Pin reset clears deb without a debounce; skip that edge
        property p_deb;
            core_rst_n && $changed(deb) |-> deb == $past(dim_control_input[i], 1)
                && $past(dim_control_input[i], 8) == deb;
        endproperty
        a_deb: assert property (p_deb) else $error("debounce");
    end

    // ****************************************************************
    // Result store and read path
    // ****************************************************************
    always_comb
    begin
        mem_we = 7'h00;
        if (adc.valid)
        begin
            mem_we[adc.src] = 1'b1;
            if (adc.src == LXD_SRC_STR0 && dim_input_level[0])
                mem_we[`LXD_STR_ON_IDX0] = 1'b1;
            if (adc.src == LXD_SRC_STR1 && dim_input_level[1])
                mem_we[`LXD_STR_ON_IDX0 + 3'h1] = 1'b1;
        end
    end

    lxd_result_mem u_mem (
        .clk   (clk),
        .rst_n (core_rst_n),
        .we    (mem_we),
        .wcode (adc.code),
        .raddr (3'(req.addr - `LXD_RESULT_BASE)),
        .rdata (mem_rdata)
    );

    always_comb
    begin
        next_rd_mem = req.addr >= `LXD_RESULT_BASE
            && req.addr <= `LXD_RESULT_LAST;
        unique case (req.addr)
            `LXD_CTRL_OFS:       next_rd_val = ctrl;
            `LXD_WARN_THR_OFS:   next_rd_val = {8'h00, warn_temp_threshold};
            `LXD_FORCED_PER_OFS: next_rd_val = {7'h00, forced_measure_period};
            `LXD_FS_MODE_OFS:    next_rd_val = {13'h0000, failsafe_mode_sel};
            `LXD_ON_TIME0_OFS:   next_rd_val = {8'h00, on_time_measure[0]};
            `LXD_ON_TIME1_OFS:   next_rd_val = {8'h00, on_time_measure[1]};
            `LXD_LED_FAULT_OFS:  next_rd_val = {4'h0, dim_input_level,
                buck_run, min_on_time_flag, overcurrent_flag,
                short_string_flag, open_string_flag};
            `LXD_DEV_FAULT_OFS:  next_rd_val = {12'h000, hw_reset_flag,
                link_error_flag, thermal_shutdown_flag,
                thermal_warning_flag};
            default:             next_rd_val = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge core_rst_n)
    begin
        if (!core_rst_n)
        begin
            rd_val <= 16'h0000;
            rd_mem <= 1'b0;
        end
        else
        begin
            rd_val <= next_rd_val;
            rd_mem <= next_rd_mem;
        end
    end

    assign rdata = rd_mem ? {7'h00, mem_rdata} : rd_val;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_parity;
        rd_mem |-> ^rdata[8:0] == 1'b1;
    endproperty
    a_parity: assert property (p_parity) else $error("parity");

    property p_tw;
        die_temp_code >= warn_temp_threshold |=> thermal_warning_flag;
    endproperty
    a_tw: assert property (p_tw) else $error("warning");

    property p_tsd_off;
        therm == LXD_TH_SHUTDOWN |-> buck_run == 2'b00;
    endproperty
    a_tsd_off: assert property (p_tsd_off) else $error("shutdown");

    property p_tsd_exit;
        (therm == LXD_TH_SHUTDOWN && die_temp_code < warn_temp_threshold)
            |=> therm == LXD_TH_NORMAL;
    endproperty
    a_tsd_exit: assert property (p_tsd_exit) else $error("exit");

endmodule

// ===== core/lxd_pkg.sv
// Types shared by the diagnostics block
package lxd_pkg;

    typedef enum logic [2:0] {
        LXD_SRC_SUPPLY,
        LXD_SRC_BOOST,
        LXD_SRC_TEMP,
        LXD_SRC_STR0,
        LXD_SRC_STR1
    } lxd_src_e;

    typedef struct packed {
        logic       valid;
        lxd_src_e   src;
        logic [7:0] code;
    } lxd_adc_s;

    typedef struct packed {
        logic on_phase;
        logic short_cmp;
        logic zero_cross;
        logic oc_over;
        logic period_tick;
        logic min_ton;
    } lxd_buck_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } lxd_req_s;

    typedef enum logic {
        LXD_TH_NORMAL,
        LXD_TH_SHUTDOWN
    } lxd_therm_e;

endpackage

// ===== core/lxd_result_mem.sv
// Parity-protected converter result store with registered read
`timescale 1ns/1ps
`include "lxd_defs.svh"

module lxd_result_mem
    import lxd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [6:0] we,
    input  wire logic [7:0] wcode,
    input  wire logic [2:0] raddr,
    output logic      [8:0] rdata
);

    logic [8:0] word  [7];
    logic [8:0] next_rdata;

    // ****************************************************************
    // Storage
    // ****************************************************************
    for (genvar i = 0; i < 7; i++)
    begin : g_word
        logic [8:0] next_word;
        always_comb
        begin
            next_word = word[i];
            if (we[i])
                next_word = {~^wcode, wcode};
        end
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                word[i] <= 9'h100;
            else
                word[i] <= next_word;
        end
    end

    always_comb
    begin
        next_rdata = 9'h000;
        if (raddr < 3'h7)
            next_rdata = word[raddr];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 9'h000;
        else
            rdata <= next_rdata;
    end

endmodule
